// File: design/uart_rx_error_irq_wakeup.sv
// Purpose: uart receive error flags, interrupt combining, address detect, wake-up
// Assumes: shifter and transmitter live elsewhere and feed event strobes
// Notes:   registers on ahb-lite, zero wait state, okay response only
`timescale 1ns/1ns
module uart_rx_error_irq_wakeup
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rx_pin,
  input  wire logic        frame_done,
  input  wire logic [8:0]  frame_bits,
  input  wire logic        frame_par,
  input  wire logic        frame_stop1,
  input  wire logic        frame_stop2,
  input  wire logic        frame_noisy,
  input  wire logic        rx_busy,
  input  wire logic        tx_empty,
  input  wire logic        tx_idle,
  output logic             rx_hold,
  output logic             irq_n,
  output logic             wake_req
);

  //--------------------------------------------------
  // bus slave
  //--------------------------------------------------
  logic        wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
  logic [7:0]  addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        take;

  assign take = hsel && hready && (htrans == uart_rx_pkg::HTRANS_NONSEQ);

  // address phase capture
  always_comb
  begin
    wr_pend_d = take && hwrite;
    rd_pend_d = take && !hwrite;
    addr_d    = take ? haddr[7:0] : addr_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q    <= addr_d;
    end
  end

  //--------------------------------------------------
  // control registers
  //--------------------------------------------------
  logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, baud_q, baud_d, sys_q, sys_d;
  logic       clk_on;

  // plain writes; values persist through sleep
  always_comb
  begin
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    baud_d  = baud_q;
    sys_d   = sys_q;
    if (wr_pend_q)
    begin
      case (addr_q)
        uart_rx_pkg::OFF_CTRL1:  ctrl1_d = hwdata[7:0];
        uart_rx_pkg::OFF_CTRL2:  ctrl2_d = hwdata[7:0];
        uart_rx_pkg::OFF_BAUD:   baud_d  = hwdata[7:0];
        uart_rx_pkg::OFF_SYSCTL: sys_d   = hwdata[7:0];
        default:                 ctrl1_d = ctrl1_q;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1_q <= uart_rx_pkg::CTRL1_RST;
      ctrl2_q <= uart_rx_pkg::CTRL2_RST;
      baud_q  <= uart_rx_pkg::BAUD_RST;
      sys_q   <= uart_rx_pkg::SYSCTL_RST;
    end
    else
    begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      baud_q  <= baud_d;
      sys_q   <= sys_d;
    end
  end

  assign clk_on = sys_q[uart_rx_pkg::SC_CLKON];

  //--------------------------------------------------
  // wake-up sequencing
  //--------------------------------------------------
  uart_rx_pkg::wake_state_t       wst_q, wst_d;
  logic [uart_rx_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic                           wake_arm, wake_seen, wake_clr, wake_irq_d, wake_irq_q;
  logic                           ints_on;

  assign ints_on  = sys_q[uart_rx_pkg::SC_GIE] && sys_q[uart_rx_pkg::SC_UIE];
  assign wake_arm = !clk_on && ctrl2_q[uart_rx_pkg::C2_WAKE] && ctrl1_q[uart_rx_pkg::C1_MODE]
                    && ctrl1_q[uart_rx_pkg::C1_EN] && ctrl2_q[uart_rx_pkg::C2_RXEN]
                    && ctrl2_q[uart_rx_pkg::C2_RIE];
  assign wake_clr = (wst_q == uart_rx_pkg::WK_HOLD) && (cnt_q == '0);

  wake_detect u_wake
  (
    .clk    (clk),
    .rst    (rst),
    .rx_pin (rx_pin),
    .arm    (wake_arm),
    .clear  (wake_clr),
    .seen   (wake_seen)
  );

  // start-up delay before interrupt and data capture resume
  always_comb
  begin
    wst_d      = wst_q;
    cnt_d      = cnt_q;
    wake_irq_d = 1'b0;
    case (wst_q)
      uart_rx_pkg::WK_RUN:
        if (wake_seen)
        begin
          wst_d = uart_rx_pkg::WK_START;
          cnt_d = uart_rx_pkg::CNT_W'(uart_rx_pkg::STARTUP_CYCLES - 1);
        end
      uart_rx_pkg::WK_START:
        if (cnt_q == '0)
        begin
          wst_d      = uart_rx_pkg::WK_HOLD;
          wake_irq_d = ints_on;
        end
        else
          cnt_d = cnt_q - 1'b1;
      uart_rx_pkg::WK_HOLD:
        if (!wake_seen)
          wst_d = uart_rx_pkg::WK_RUN;
      default:
        wst_d = uart_rx_pkg::WK_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wst_q      <= uart_rx_pkg::WK_RUN;
      cnt_q      <= '0;
      wake_irq_q <= 1'b0;
    end
    else
    begin
      wst_q      <= wst_d;
      cnt_q      <= cnt_d;
      wake_irq_q <= wake_irq_d;
    end
  end

  //--------------------------------------------------
  // frame check and status flags
  //--------------------------------------------------
  rx_word_if w ();
  logic ignore;

  assign ignore = (wst_q == uart_rx_pkg::WK_START) || !clk_on;

  rx_frame_check u_chk
  (
    .clk      (clk),
    .rst      (rst),
    .done     (frame_done && !ignore),
    .bits     (frame_bits),
    .par_bit  (frame_par),
    .stop1    (frame_stop1),
    .stop2    (frame_stop2),
    .noisy    (frame_noisy),
    .nine     (ctrl1_q[uart_rx_pkg::C1_NINE]),
    .par_en   (ctrl1_q[uart_rx_pkg::C1_PREN]),
    .par_odd  (ctrl1_q[uart_rx_pkg::C1_PODD]),
    .two_stop (ctrl1_q[uart_rx_pkg::C1_STOP2]),
    .w        (w)
  );

  logic [8:0] data_q, data_d;
  logic       ferr_q, ferr_d, perr_q, perr_d, oerr_q, oerr_d, nf_q, nf_d;
  logic       rxif_q, rxif_d, stat_seen_q, stat_seen_d, rd_data, rd_stat, addr_hit;
  logic       irq_n_q, irq_n_d, wake_req_q, rx_hold_q;
  logic [5:0] cond;

  assign rd_stat = rd_pend_q && (addr_q == uart_rx_pkg::OFF_STATUS);
  assign rd_data = rd_pend_q && (addr_q == uart_rx_pkg::OFF_DATA);

  // top received bit picks 9th or 8th
  function automatic logic top_bit(input logic [8:0] d, input logic nine);
    top_bit = nine ? d[8] : d[7];
  endfunction

  // flags set by hardware only, set wins over clear
  always_comb
  begin
    data_d      = data_q;
    ferr_d      = ferr_q;
    perr_d      = perr_q;
    oerr_d      = oerr_q;
    nf_d        = nf_q;
    rxif_d      = rxif_q;
    stat_seen_d = stat_seen_q || rd_stat;
    if (rd_data && stat_seen_q)
    begin
      oerr_d      = 1'b0;
      nf_d        = 1'b0;
      rxif_d      = 1'b0;
      stat_seen_d = 1'b0;
    end
    if (w.valid)
    begin
      if (rxif_q && !(rd_data && stat_seen_q))
        oerr_d = 1'b1;
      else
      begin
        data_d = w.data;
        ferr_d = w.frame_err;
        perr_d = w.parity_err;
        nf_d   = nf_d || w.noise;
        rxif_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_q      <= 9'h000;
      ferr_q      <= 1'b0;
      perr_q      <= 1'b0;
      oerr_q      <= 1'b0;
      nf_q        <= 1'b0;
      rxif_q      <= 1'b0;
      stat_seen_q <= 1'b0;
    end
    else
    begin
      data_q      <= data_d;
      ferr_q      <= ferr_d;
      perr_q      <= perr_d;
      oerr_q      <= oerr_d;
      nf_q        <= nf_d;
      rxif_q      <= rxif_d;
      stat_seen_q <= stat_seen_d;
    end
  end

  //--------------------------------------------------
  // interrupt combining
  //--------------------------------------------------
  logic [3:0] prev_q, prev_d;
  logic       any_rise, rx_new;

  assign addr_hit = ctrl2_q[uart_rx_pkg::C2_ADDEN] && w.valid
                    && top_bit(w.data, ctrl1_q[uart_rx_pkg::C1_NINE]);
  assign rx_new   = rxif_d && !rxif_q;

  // gated conditions, edge-detected to a single low pulse
  always_comb
  begin
    cond[0] = tx_empty && ctrl2_q[uart_rx_pkg::C2_TEIE];
    cond[1] = tx_idle && ctrl2_q[uart_rx_pkg::C2_TIIE];
    cond[2] = rx_new && ctrl2_q[uart_rx_pkg::C2_RIE]
              && (!ctrl2_q[uart_rx_pkg::C2_ADDEN]
                  || top_bit(data_d, ctrl1_q[uart_rx_pkg::C1_NINE]));
    cond[3] = oerr_d && !oerr_q && ctrl2_q[uart_rx_pkg::C2_RIE];
    cond[4] = addr_hit;
    cond[5] = wake_irq_q;
    prev_d   = cond[3:0];
    any_rise = (cond[0] && !prev_q[0]) || (cond[1] && !prev_q[1]) || cond[2] || cond[3]
               || cond[4] || cond[5];
    irq_n_d  = !(any_rise && clk_on);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prev_q     <= 4'h0;
      irq_n_q    <= 1'b1;
      wake_req_q <= 1'b0;
      rx_hold_q  <= 1'b0;
    end
    else
    begin
      prev_q     <= prev_d;
      irq_n_q    <= irq_n_d;
      wake_req_q <= wake_seen && (wst_q == uart_rx_pkg::WK_RUN);
      rx_hold_q  <= !clk_on && rx_busy;
    end
  end

  //--------------------------------------------------
  // read mux
  //--------------------------------------------------
  always_comb
  begin
    hrdata_d = 32'h0000_0000;
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        uart_rx_pkg::OFF_STATUS: hrdata_d = {24'h000000, tx_empty, tx_idle, rxif_q, !rx_busy,
                                             oerr_q, ferr_q, nf_q, perr_q};
        uart_rx_pkg::OFF_CTRL1:  hrdata_d = {24'h000000, ctrl1_q[7:1], data_q[8]};
        uart_rx_pkg::OFF_CTRL2:  hrdata_d = {24'h000000, ctrl2_q};
        uart_rx_pkg::OFF_DATA:   hrdata_d = {24'h000000, data_q[7:0]};
        uart_rx_pkg::OFF_BAUD:   hrdata_d = {24'h000000, baud_q};
        uart_rx_pkg::OFF_SYSCTL: hrdata_d = {24'h000000, sys_q};
        default:                 hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hrdata_q <= 32'h0000_0000;
    else
      hrdata_q <= hrdata_d;
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq_n     = irq_n_q;
  assign wake_req  = wake_req_q;
  assign rx_hold   = rx_hold_q;

endmodule // uart_rx_error_irq_wakeup

// File: inc/uart_rx_pkg.sv
// Purpose: shared constants and types for the uart receive error / irq block
// Assumes: 32-bit ahb-lite register bus, 10 MHz clock
// Notes:   byte offsets of the register words, field positions, reset values
package uart_rx_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_CTRL1   = 8'h04;
  localparam logic [7:0] OFF_CTRL2   = 8'h08;
  localparam logic [7:0] OFF_DATA    = 8'h0c;
  localparam logic [7:0] OFF_BAUD    = 8'h10;
  localparam logic [7:0] OFF_SYSCTL  = 8'h14;

  // status fields
  localparam int ST_PERR  = 0;
  localparam int ST_NF    = 1;
  localparam int ST_FERR  = 2;
  localparam int ST_OERR  = 3;
  localparam int ST_RIDLE = 4;
  localparam int ST_RXIF  = 5;
  localparam int ST_TIDLE = 6;
  localparam int ST_TXIF  = 7;

  // control one fields
  localparam int C1_MODE  = 7;
  localparam int C1_EN    = 6;
  localparam int C1_NINE  = 5;
  localparam int C1_PREN  = 4;
  localparam int C1_PODD  = 3;
  localparam int C1_STOP2 = 2;

  // control two fields
  localparam int C2_RXEN  = 7;
  localparam int C2_ADDEN = 5;
  localparam int C2_WAKE  = 4;
  localparam int C2_RIE   = 3;
  localparam int C2_TIIE  = 2;
  localparam int C2_TEIE  = 1;

  // system control fields
  localparam int SC_GIE   = 0;
  localparam int SC_UIE   = 1;
  localparam int SC_CLKON = 2;

  // reset values
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL2_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST   = 8'h00;
  localparam logic [7:0] SYSCTL_RST = 8'h04;

  // start-up time after wake-up
  localparam int STARTUP_NS     = 1600;
  localparam int CLK_NS         = 100;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W          = 8;

  // ahb htrans codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0]
  {
    WK_RUN   = 3'h1,
    WK_START = 3'h2,
    WK_HOLD  = 3'h4
  } wake_state_t;

endpackage

// File: inc/rx_word_if.sv
// Purpose: carries a finished received word from the frame checker
// Assumes: one-cycle valid strobe
// Notes:   error bits travel with their word
`timescale 1ns/1ns
interface rx_word_if;
  logic       valid;
  logic [8:0] data;
  logic       frame_err;
  logic       parity_err;
  logic       noise;

  modport src (output valid, output data, output frame_err, output parity_err, output noise);
  modport dst (input valid, input data, input frame_err, input parity_err, input noise);
endinterface

// File: design/rx_frame_check.sv
// Purpose: checks stop and parity bits of a completed receive frame
// Assumes: shifter presents raw frame with a one-cycle done strobe
// Notes:   pure combinational qualification plus one register stage
`timescale 1ns/1ns
module rx_frame_check
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       done,
  input  wire logic [8:0] bits,
  input  wire logic       par_bit,
  input  wire logic       stop1,
  input  wire logic       stop2,
  input  wire logic       noisy,
  input  wire logic       nine,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  input  wire logic       two_stop,
  rx_word_if.src          w
);

  logic       valid_d, valid_q;
  logic [8:0] data_d, data_q;
  logic       ferr_d, ferr_q, perr_d, perr_q, nf_d, nf_q;
  logic       ones;

  // error evaluation
  always_comb
  begin
    ones    = ^(nine ? bits : {1'b0, bits[7:0]});
    valid_d = done;
    data_d  = nine ? bits : {1'b0, bits[7:0]};
    ferr_d  = !stop1 || (two_stop && !stop2);
    perr_d  = par_en && ((ones ^ par_bit) != par_odd);
    nf_d    = noisy;
  end

  // register stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      valid_q <= 1'b0;
      data_q  <= 9'h000;
      ferr_q  <= 1'b0;
      perr_q  <= 1'b0;
      nf_q    <= 1'b0;
    end
    else
    begin
      valid_q <= valid_d;
      data_q  <= data_d;
      ferr_q  <= ferr_d;
      perr_q  <= perr_d;
      nf_q    <= nf_d;
    end
  end

  assign w.valid      = valid_q;
  assign w.data       = data_q;
  assign w.frame_err  = ferr_q;
  assign w.parity_err = perr_q;
  assign w.noise      = nf_q;

endmodule // rx_frame_check

// File: design/wake_detect.sv
// Purpose: falling-edge wake-up catcher on the receive pin
// Assumes: module clock may be stopped; latch set with no clock
// Notes:   latch is synchronised with two flops once the clock runs
`timescale 1ns/1ns
module wake_detect
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rx_pin,
  input  wire logic arm,
  input  wire logic clear,
  output logic      seen
);

  logic latch_q, s1_q, s2_q;

  // asynchronously set on rx falling edge while armed
  always_ff @(negedge rx_pin or posedge rst or posedge clear)
  begin
    if (rst || clear)
      latch_q <= 1'b0;
    else if (arm)
      latch_q <= 1'b1;
  end

  // two-flop synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= latch_q;
      s2_q <= s1_q;
    end
  end

  assign seen = s2_q;

endmodule // wake_detect

// File: bench/uart_rx_error_irq_wakeup_props.sv
// Purpose: port-level checks of the receive error and irq block
// Assumes: control words are mirrored from bus writes
// Notes:   bound into every instance of the top module
`timescale 1ns/1ns
module uart_rx_props
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        rx_pin,
  input wire logic        frame_done,
  input wire logic [8:0]  frame_bits,
  input wire logic        rx_busy,
  input wire logic        tx_empty,
  input wire logic        irq_n,
  input wire logic        wake_req,
  input wire logic        rx_hold
);
  // ----------------------------------------
  // control mirror and checks
  // ----------------------------------------
  logic       wr_q;
  logic [7:0] a_q;
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [7:0] sc_q;
  logic [uart_rx_pkg::CNT_W-1:0] su_q;
  // words stored at the edge closing the data phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= 1'b0;
      a_q  <= 8'h00;
      c1_q <= uart_rx_pkg::CTRL1_RST;
      c2_q <= uart_rx_pkg::CTRL2_RST;
      sc_q <= uart_rx_pkg::SYSCTL_RST;
    end
    else
    begin
      wr_q <= hsel && hready && htrans == uart_rx_pkg::HTRANS_NONSEQ && hwrite;
      a_q  <= haddr[7:0];
      if (wr_q && a_q == uart_rx_pkg::OFF_CTRL1)
        c1_q <= hwdata[7:0];
      if (wr_q && a_q == uart_rx_pkg::OFF_CTRL2)
        c2_q <= hwdata[7:0];
      if (wr_q && a_q == uart_rx_pkg::OFF_SYSCTL)
        sc_q <= hwdata[7:0];
    end
  end
  // start-up window after a wake-up, words are dropped there
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      su_q <= '0;
    else if (wake_req)
      su_q <= uart_rx_pkg::CNT_W'(uart_rx_pkg::STARTUP_CYCLES);
    else if (su_q != '0)
      su_q <= su_q - 1'b1;
  end
  // enable groups
  wire ie_on = sc_q[uart_rx_pkg::SC_GIE] && sc_q[uart_rx_pkg::SC_UIE];
  wire on    = sc_q[uart_rx_pkg::SC_CLKON];
  wire uon   = c1_q[uart_rx_pkg::C1_MODE] && c1_q[uart_rx_pkg::C1_EN]
               && c2_q[uart_rx_pkg::C2_RXEN] && c2_q[uart_rx_pkg::C2_RIE];
  wire rx_on = ie_on && on && uon && !wake_req && su_q == '0;
  wire adden = c2_q[uart_rx_pkg::C2_ADDEN];
  wire top_b = c1_q[uart_rx_pkg::C1_NINE] ? frame_bits[8] : frame_bits[7];
  wire armed = !on && uon && c2_q[uart_rx_pkg::C2_WAKE];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence irq_at2;
    ##2 !irq_n;
  endsequence
  sequence quiet8;
    irq_n [*8];
  endsequence

  irq_pulse_a: assert property ($fell(irq_n) |=> irq_n)
    else $error("irq low longer than one cycle");
  rx_data_irq_a: assert property (frame_done && rx_on && !adden |-> irq_at2)
    else $error("no irq for received word");
  addr_irq_a: assert property (frame_done && rx_on && adden && top_b |-> irq_at2)
    else $error("no irq for address word");
  tx_irq_a: assert property ($rose(tx_empty) && ie_on && on
    && c2_q[uart_rx_pkg::C2_TEIE] |-> ##[1:3] !irq_n)
    else $error("no irq for transmit empty");
  wake_edge_a: assert property ($fell(rx_pin) && armed |-> ##[1:6] wake_req)
    else $error("falling edge did not wake");
  wake_delay_a: assert property ($rose(wake_req) |-> quiet8 ##1 irq_n [*6])
    else $error("wake irq before start-up time");
  wake_mask_a: assert property ($rose(wake_req) && !ie_on
    |-> quiet8 ##1 quiet8 ##1 quiet8)
    else $error("wake irq while masked");
  rx_hold_a: assert property (rx_busy && !on |-> ##[0:2] rx_hold)
    else $error("reception not suspended");
endmodule // uart_rx_props

bind uart_rx_error_irq_wakeup uart_rx_props chk (.clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .rx_pin, .frame_done, .frame_bits, .rx_busy, .tx_empty,
  .irq_n, .wake_req, .rx_hold);

// File: bench/rx_frame_src.sv
// Purpose: remote sender as seen through the receive shifter
// Assumes: tasks are called just after a rising clock edge
// Notes:   released word lines show the inverse of the last word
`timescale 1ns/1ns
module rx_frame_src
(
  input  wire logic  clk,
  output logic       rx_pin,
  output logic       frame_done,
  output logic [8:0] frame_bits,
  output logic       frame_par,
  output logic       frame_stop1,
  output logic       frame_stop2,
  output logic       frame_noisy,
  output logic       rx_busy
);
  // ----------------------------------------
  // frame and pin activity
  // ----------------------------------------
  initial
  begin
    {rx_pin, frame_done, rx_busy} = 3'b100;
    {frame_bits, frame_par, frame_stop1, frame_stop2, frame_noisy} = 13'h0;
  end
  // start bit, gap cycles of shifting, then the word for one cycle
  task automatic send(input logic [8:0] b, input logic p, input logic s1,
                      input logic s2, input logic nz, input int gap);
    rx_pin  <= 1'b0;
    rx_busy <= 1'b1;
    repeat (gap) @(posedge clk);
    {frame_bits, frame_par, frame_stop1, frame_stop2, frame_noisy} <= {b, p, s1, s2, nz};
    frame_done <= 1'b1;
    rx_pin     <= s1;
    @(posedge clk);
    {frame_bits, frame_par, frame_stop1, frame_stop2, frame_noisy} <= ~{b, p, s1, s2, nz};
    frame_done <= 1'b0;
    rx_busy    <= 1'b0;
    rx_pin     <= 1'b1;
    @(posedge clk);
  endtask
  // line pulled low a few cycles, a wake-up edge
  task automatic fall();
    rx_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rx_pin <= 1'b1;
    @(posedge clk);
  endtask
  // receiver caught mid-frame
  task automatic hold(input logic v);
    rx_busy <= v;
    @(posedge clk);
  endtask
endmodule // rx_frame_src

// File: bench/test_uart_rx_error_irq_wakeup.sv
// Purpose: self-checking bench for the receive error and irq block
// Assumes: zero wait state bus slave, 10 MHz clock
// Notes:   words come from the remote sender model
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_uart_rx_error_irq_wakeup;
  // ----------------------------------------
  // signals, models, bus tasks
  // ----------------------------------------
  logic        clk, rst, hsel, hwrite, tx_empty, tx_idle, fe, pe;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd;
  logic [8:0]  dw;
  wire  [31:0] hrdata;
  wire  [8:0]  frame_bits;
  wire         hreadyout, hresp, rx_hold, irq_n, wake_req, rx_pin, frame_done;
  wire         frame_par, frame_stop1, frame_stop2, frame_noisy, rx_busy;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          irqs = 0;
  int          k0;
  logic [7:0]  cf [8] = '{8'hc0, 8'hc4, 8'hc4, 8'hd0, 8'hd8, 8'hc8, 8'hf0, 8'hf8};
  logic [8:0]  bt [8] = '{9'h0a5, 9'h03c, 9'h0ff, 9'h003, 9'h003, 9'h003, 9'h100, 9'h1fe};
  logic [2:0]  fl [8] = '{3'h1, 3'h2, 3'h3, 3'h7, 3'h7, 3'h3, 3'h3, 3'h7};
  logic [8:0]  ad [4] = '{9'h07f, 9'h080, 9'h0ff, 9'h100};

  uart_rx_error_irq_wakeup dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rx_pin, .frame_done,
    .frame_bits, .frame_par, .frame_stop1, .frame_stop2, .frame_noisy, .rx_busy, .tx_empty,
    .tx_idle, .rx_hold, .irq_n, .wake_req);
  rx_frame_src src (.clk, .rx_pin, .frame_done, .frame_bits, .frame_par, .frame_stop1,
    .frame_stop2, .frame_noisy, .rx_busy);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // counts request pulses away from the sampling edge
  always @(negedge clk)
    if (irq_n === 1'b0)
      irqs++;

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= uart_rx_pkg::HTRANS_NONSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    `CHK({hresp, rd & {24'h0, m}}, {1'b0, 24'h0, e})
  endtask
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] sc);
    bus(1'b1, uart_rx_pkg::OFF_CTRL1, {24'h0, c1});
    bus(1'b1, uart_rx_pkg::OFF_CTRL2, {24'h0, c2});
    bus(1'b1, uart_rx_pkg::OFF_SYSCTL, {24'h0, sc});
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #(100 * 6000);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    {rst, hsel, hwrite, tx_empty, tx_idle} = 5'h10;
    {htrans, haddr, hwdata} = 66'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(uart_rx_pkg::OFF_CTRL2, 8'hff, uart_rx_pkg::CTRL2_RST);
    rchk(uart_rx_pkg::OFF_SYSCTL, 8'hff, uart_rx_pkg::SYSCTL_RST);
    rchk(uart_rx_pkg::OFF_BAUD, 8'hff, uart_rx_pkg::BAUD_RST);
    bus(1'b1, 8'h1c, 32'hff);
    rchk(8'h1c, 8'hff, 8'h00);
    bus(1'b1, uart_rx_pkg::OFF_STATUS, 32'hff);
    rchk(uart_rx_pkg::OFF_STATUS, 8'h2f, 8'h00);
    bus(1'b1, uart_rx_pkg::OFF_BAUD, 32'h5a);
    cfg(8'hc0, 8'h88, 8'h07);
    // stop and parity checking over seven of the formats, eight words
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, uart_rx_pkg::OFF_CTRL1, {24'h0, cf[i]});
      k0 = irqs;
      src.send(bt[i], fl[i][2], fl[i][1], fl[i][0], 1'b0, 1 + i % 3);
      repeat (3) @(posedge clk);
      dw = cf[i][uart_rx_pkg::C1_NINE] ? bt[i] : {1'b0, bt[i][7:0]};
      fe = !fl[i][1] || (cf[i][uart_rx_pkg::C1_STOP2] && !fl[i][0]);
      pe = cf[i][uart_rx_pkg::C1_PREN] && ((^dw ^ fl[i][2]) != cf[i][uart_rx_pkg::C1_PODD]);
      `CHK(irqs - k0, 1)
      rchk(uart_rx_pkg::OFF_CTRL1, {7'h0, cf[i][5]}, {7'h0, bt[i][8]});
      rchk(uart_rx_pkg::OFF_STATUS, 8'h25, {5'h04, fe, 1'b0, pe});
      rchk(uart_rx_pkg::OFF_DATA, 8'hff, bt[i][7:0]);
      rchk(uart_rx_pkg::OFF_STATUS, 8'h20, 8'h00);
    end
    // a reset in mid-run clears a stored frame error
    src.send(9'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rchk(uart_rx_pkg::OFF_STATUS, 8'h2f, 8'h00);
    bus(1'b1, uart_rx_pkg::OFF_BAUD, 32'h5a);
    cfg(8'hc0, 8'h88, 8'h07);
    // noisy word then an overrun; the buffer keeps the first word
    src.send(9'h011, 1'b0, 1'b1, 1'b1, 1'b1, 1);
    src.send(9'h022, 1'b0, 1'b1, 1'b1, 1'b0, 2);
    rchk(uart_rx_pkg::OFF_STATUS, 8'h2a, 8'h2a);
    rchk(uart_rx_pkg::OFF_DATA, 8'hff, 8'h11);
    rchk(uart_rx_pkg::OFF_STATUS, 8'h2a, 8'h00);
    // address words with parity off, 8 and 9 bit
    for (int i = 0; i < 4; i++)
    begin
      cfg(i < 2 ? 8'hc0 : 8'he0, 8'ha8, 8'h07);
      k0 = irqs;
      src.send(ad[i], 1'b0, 1'b1, 1'b1, 1'b0, 2);
      repeat (3) @(posedge clk);
      `CHK(irqs - k0, int'(i < 2 ? ad[i][7] : ad[i][8]))
      bus(1'b0, uart_rx_pkg::OFF_STATUS, 32'h0);
      bus(1'b0, uart_rx_pkg::OFF_DATA, 32'h0);
    end
    // transmit sources, one masked
    cfg(8'hc0, 8'h82, 8'h07);
    k0 = irqs;
    tx_empty <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(irqs - k0, 1)
    tx_idle <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(irqs - k0, 1)
    rchk(uart_rx_pkg::OFF_STATUS, 8'hc0, 8'hc0);
    bus(1'b1, uart_rx_pkg::OFF_CTRL2, 32'h84);
    k0 = irqs;
    tx_idle <= 1'b0;
    repeat (2) @(posedge clk);
    tx_idle <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(irqs - k0, 1)
    {tx_empty, tx_idle} <= 2'b00;
    // clock stopped mid-frame, contents kept
    cfg(8'hc0, 8'h88, 8'h07);
    src.hold(1'b1);
    bus(1'b1, uart_rx_pkg::OFF_SYSCTL, 32'h03);
    repeat (3) @(posedge clk);
    `CHK(rx_hold, 1'b1)
    rchk(uart_rx_pkg::OFF_CTRL2, 8'hff, 8'h88);
    rchk(uart_rx_pkg::OFF_BAUD, 8'hff, 8'h5a);
    bus(1'b1, uart_rx_pkg::OFF_SYSCTL, 32'h07);
    repeat (3) @(posedge clk);
    `CHK(rx_hold, 1'b0)
    src.hold(1'b0);
    // wake-up enabled, then masked
    for (int i = 0; i < 2; i++)
    begin
      cfg(8'hc0, 8'h98, i == 0 ? 8'h03 : 8'h00);
      k0 = irqs;
      src.fall();
      for (int n = 0; n < 10 && wake_req !== 1'b1; n++) @(posedge clk);
      `CHK(wake_req, 1'b1)
      bus(1'b1, uart_rx_pkg::OFF_SYSCTL, i == 0 ? 32'h07 : 32'h04);
      src.send(9'h055, 1'b0, 1'b1, 1'b1, 1'b0, 1);
      repeat (40) @(posedge clk);
      `CHK(irqs - k0, 1 - i)
      rchk(uart_rx_pkg::OFF_STATUS, 8'h20, 8'h00);
    end
    finish_test();
  end
endmodule // test_uart_rx_error_irq_wakeup
